// >>> hdl/ssbr_pkg.sv
// Constants for the sensor status and burst register block.
// Assumes one 40 MHz core clock and an 8-bit serial register port.
// Notes on behaviour
// - Firmware revision reads downloaded revision only when download succeeded and running, else zero.
// - Silicon revision stays separate and reads from its own address one.
// - Observation bit 7 is set while the chip runs shadow firmware.
// - Observation bit 5 is set when a power-down input pulse is seen.
// - Observation bits are set by their processes; bits 1 and 0 every frame.
// - Writing zero clears observation bits; controller waits, then reads back.
// - Address 0x3F returns the bitwise complement of the part code.
// - Pixel burst reads stream every pixel of one and two-thirds frames.
// - Motion burst streams motion, X, Y, quality, shutter high, low, max pixel.
// - Download port is write-only; successive bytes load firmware at high speed.
`default_nettype none

package ssbr_pkg;
	localparam int ADDR_W = 7;
	localparam logic [6:0] ADDR_PART_CODE = 7'h00;
	localparam logic [6:0] ADDR_SILICON_REV = 7'h01;
	localparam logic [6:0] ADDR_FW_REV = 7'h1F;
	localparam logic [6:0] ADDR_OBS = 7'h3D;
	localparam logic [6:0] ADDR_CPART_CODE = 7'h3F;
	localparam logic [6:0] ADDR_PIXEL_BURST = 7'h40;
	localparam logic [6:0] ADDR_MOTION_BURST = 7'h50;
	localparam logic [6:0] ADDR_FW_LOAD = 7'h60;
	localparam int OBS_RUNNING_BIT = 7;
	localparam int OBS_PD_BIT = 5;
	localparam int OBS_TICK_B_BIT = 1;
	localparam int OBS_TICK_A_BIT = 0;
	localparam logic [7:0] OBS_MASK = 8'hA3;
	localparam logic [7:0] OBS_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int MOTION_LEN = 7;
	localparam int PIXEL_BURST_LEN = 1500;
	localparam logic [2:0] PIN_SYNC_RESET = 3'h3;
	localparam logic [2:0] BIT_LAST = 3'h7;
endpackage

`default_nettype wire

// >>> hdl/ssbr_link_if.sv
// Byte-level carrier between the serial link and the register bank.
// Assumes both ends run on the same core clock.
`default_nettype none

interface ssbr_link_if;
	logic sel;
	logic rx_valid;
	logic rx_first;
	logic [7:0] rx_data;
	logic [7:0] tx_data;
	modport link
	(
		output sel,
		output rx_valid,
		output rx_first,
		output rx_data,
		input tx_data
	);
	modport regs
	(
		input sel,
		input rx_valid,
		input rx_first,
		input rx_data,
		output tx_data
	);
endinterface

`default_nettype wire

// >>> hdl/ssbr_serial_link.sv
// Four-wire serial slave, mode 3, oversampled by the core clock.
// Assumes serial clock well below a quarter of the core clock.
`default_nettype none

module ssbr_serial_link
	import ssbr_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ncs_pin,
	input wire logic sclk_pin,
	input wire logic mosi_pin,
	output logic miso_o,
	output logic miso_oe,
	ssbr_link_if.link bus
);
	logic [2:0] pins;
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic [2:0] s3_reg;
	logic [2:0] filt_reg;
	logic [2:0] prev_reg;
	logic sclk_rise;
	logic sclk_fall;
	logic [2:0] bit_cnt_reg;
	logic [7:0] rx_shift_reg;
	logic first_reg;
	logic [7:0] tx_shift_reg;

	assign pins = {mosi_pin, sclk_pin, ncs_pin};

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_reg <= PIN_SYNC_RESET;
			s2_reg <= PIN_SYNC_RESET;
			s3_reg <= PIN_SYNC_RESET;
		end
		else
		begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// A pin change counts once the last two stages agree
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			filt_reg <= PIN_SYNC_RESET;
			prev_reg <= PIN_SYNC_RESET;
		end
		else
		begin
			for (int i = 0; i < 3; i++)
				if (s2_reg[i] == s3_reg[i])
					filt_reg[i] <= s3_reg[i];
			prev_reg <= filt_reg;
		end
	end

	assign sclk_rise = filt_reg[1] & ~prev_reg[1];
	assign sclk_fall = ~filt_reg[1] & prev_reg[1];
	assign bus.sel = ~filt_reg[0];

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			bit_cnt_reg <= 3'h0;
			rx_shift_reg <= BYTE_ZERO;
			first_reg <= 1'b1;
			bus.rx_valid <= 1'b0;
			bus.rx_first <= 1'b0;
			bus.rx_data <= BYTE_ZERO;
		end
		else
		begin
			bus.rx_valid <= 1'b0;
			if (!bus.sel)
			begin
				bit_cnt_reg <= 3'h0;
				first_reg <= 1'b1;
			end
			else if (sclk_rise)
			begin
				rx_shift_reg <= {rx_shift_reg[6:0], filt_reg[2]};
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (bit_cnt_reg == BIT_LAST)
				begin
					bus.rx_valid <= 1'b1;
					bus.rx_data <= {rx_shift_reg[6:0], filt_reg[2]};
					bus.rx_first <= first_reg;
					first_reg <= 1'b0;
				end
			end
		end
	end

	// Next answer byte is taken on the first falling edge of each byte
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_shift_reg <= BYTE_ZERO;
			miso_oe <= 1'b0;
		end
		else
		begin
			miso_oe <= bus.sel;
			if (bus.sel && sclk_fall)
			begin
				if (bit_cnt_reg == 3'h0)
					tx_shift_reg <= bus.tx_data;
				else
					tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
			end
		end
	end

	assign miso_o = tx_shift_reg[7];
endmodule

`default_nettype wire

// >>> hdl/ssbr_regs.sv
// Upper register map: revisions, observation flags, part code check,
// pixel and motion burst ports and the firmware download port.
// Assumes frame_tick is a core-clock pulse and pixel_data follows pixel_index combinationally.
`default_nettype none

module ssbr_regs
	import ssbr_pkg::*;
#(
	// Arbitrary identity values
	parameter logic [7:0] PART_CODE = 8'h5A,
	parameter logic [7:0] SILICON_REV = 8'h01,
	parameter int PIX_W = 11,
	parameter int PIX_LEN = PIXEL_BURST_LEN
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ncs_pin,
	input wire logic sclk_pin,
	input wire logic mosi_pin,
	output logic miso_o,
	output logic miso_oe,
	input wire logic power_down_n,
	input wire logic frame_tick,
	input wire logic firmware_running,
	input wire logic fw_download_ok,
	input wire logic [7:0] fw_revision,
	input wire logic [7:0] motion_in,
	input wire logic [7:0] delta_x_in,
	input wire logic [7:0] delta_y_in,
	input wire logic [7:0] surface_quality,
	input wire logic [15:0] shutter_in,
	input wire logic [7:0] max_pixel_in,
	output logic [PIX_W-1:0] pixel_index,
	input wire logic [7:0] pixel_data,
	output logic fw_load_valid,
	output logic [7:0] fw_load_data,
	output logic fw_load_active
);
	typedef enum logic [2:0] {ST_CMD, ST_WR, ST_RD, ST_MBURST, ST_PBURST, ST_LOAD} ssbr_state_t;

	ssbr_link_if lnk ();
	ssbr_state_t state_reg;
	logic [6:0] addr_reg;
	logic [7:0] tx_reg;
	logic [7:0] obs_reg;
	logic [7:0] obs_next;
	logic [7:0] obs_set;
	logic [2:0] mb_idx_reg;
	logic [7:0] mb_byte [MOTION_LEN];
	logic [2:0] pd_s_reg;
	logic pd_filt_reg;
	logic pd_prev_reg;
	logic pd_pulse;
	logic obs_write;

	ssbr_serial_link u_link
	(
		.clk(clk),
		.nrst(nrst),
		.ncs_pin(ncs_pin),
		.sclk_pin(sclk_pin),
		.mosi_pin(mosi_pin),
		.miso_o(miso_o),
		.miso_oe(miso_oe),
		.bus(lnk.link)
	);

	assign lnk.tx_data = tx_reg;
	assign mb_byte[0] = motion_in;
	assign mb_byte[1] = delta_x_in;
	assign mb_byte[2] = delta_y_in;
	assign mb_byte[3] = surface_quality;
	assign mb_byte[4] = shutter_in[15:8];
	assign mb_byte[5] = shutter_in[7:0];
	assign mb_byte[6] = max_pixel_in;

	// Single-address read map; unmapped and reserved addresses read zero
	function automatic logic [7:0] read_value(input logic [6:0] a);
		logic [7:0] v;
		v = BYTE_ZERO;
		unique case (a)
			ADDR_PART_CODE: v = PART_CODE;
			ADDR_SILICON_REV: v = SILICON_REV;
			ADDR_FW_REV: v = (fw_download_ok && firmware_running) ? fw_revision : BYTE_ZERO;
			ADDR_OBS: v = obs_reg;
			ADDR_CPART_CODE: v = ~PART_CODE;
			default: v = BYTE_ZERO;
		endcase
		return v;
	endfunction

	// Power-down input, three stages with agreement filter
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pd_s_reg <= 3'h7;
			pd_filt_reg <= 1'b1;
			pd_prev_reg <= 1'b1;
		end
		else
		begin
			pd_s_reg <= {pd_s_reg[1:0], power_down_n};
			if (pd_s_reg[1] == pd_s_reg[2])
				pd_filt_reg <= pd_s_reg[2];
			pd_prev_reg <= pd_filt_reg;
		end
	end

	assign pd_pulse = ~pd_filt_reg & pd_prev_reg;

	always_comb
	begin
		obs_set = BYTE_ZERO;
		obs_set[OBS_RUNNING_BIT] = firmware_running;
		obs_set[OBS_PD_BIT] = pd_pulse;
		obs_set[OBS_TICK_B_BIT] = frame_tick;
		obs_set[OBS_TICK_A_BIT] = frame_tick;
	end

	assign obs_write = lnk.rx_valid && state_reg == ST_WR && addr_reg == ADDR_OBS;

	assign obs_next = ((obs_write ? (obs_reg & lnk.rx_data) : obs_reg) | obs_set) & OBS_MASK;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			obs_reg <= OBS_RESET;
		else
			obs_reg <= obs_next;
	end

	// Command and burst sequencing
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= ST_CMD;
			addr_reg <= 7'h00;
			tx_reg <= BYTE_ZERO;
			mb_idx_reg <= 3'h0;
			pixel_index <= '0;
		end
		else if (!lnk.sel)
		begin
			state_reg <= ST_CMD;
			// Next pixel burst starts from the first pixel
			pixel_index <= '0;
		end
		else if (lnk.rx_valid)
		begin
			unique case (state_reg)
				ST_CMD:
				begin
					addr_reg <= lnk.rx_data[6:0];
					if (lnk.rx_data[7])
						state_reg <= (lnk.rx_data[6:0] == ADDR_FW_LOAD) ? ST_LOAD : ST_WR;
					else if (lnk.rx_data[6:0] == ADDR_MOTION_BURST)
					begin
						state_reg <= ST_MBURST;
						tx_reg <= mb_byte[0];
						mb_idx_reg <= 3'h1;
					end
					else if (lnk.rx_data[6:0] == ADDR_PIXEL_BURST)
					begin
						state_reg <= ST_PBURST;
						tx_reg <= pixel_data;
						pixel_index <= PIX_W'(1);
					end
					else
					begin
						state_reg <= ST_RD;
						tx_reg <= read_value(lnk.rx_data[6:0]);
					end
				end
				ST_WR, ST_RD:
					state_reg <= ST_CMD;
				ST_MBURST:
				begin
					tx_reg <= (mb_idx_reg < 3'(MOTION_LEN)) ? mb_byte[mb_idx_reg] : BYTE_ZERO;
					if (mb_idx_reg < 3'(MOTION_LEN))
						mb_idx_reg <= mb_idx_reg + 3'h1;
				end
				ST_PBURST:
				begin
					tx_reg <= (pixel_index < PIX_W'(PIX_LEN)) ? pixel_data : BYTE_ZERO;
					if (pixel_index < PIX_W'(PIX_LEN))
						pixel_index <= pixel_index + PIX_W'(1);
				end
				ST_LOAD:
					state_reg <= ST_LOAD;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			fw_load_valid <= 1'b0;
			fw_load_data <= BYTE_ZERO;
		end
		else
		begin
			fw_load_valid <= lnk.rx_valid && state_reg == ST_LOAD && lnk.sel;
			if (lnk.rx_valid && state_reg == ST_LOAD)
				fw_load_data <= lnk.rx_data;
		end
	end

	assign fw_load_active = state_reg == ST_LOAD;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	fwrev_gate_a: assert property (lnk.sel && lnk.rx_valid && state_reg == ST_CMD
		&& lnk.rx_data == {1'b0, ADDR_FW_REV} && !(fw_download_ok && firmware_running) |=> tx_reg == BYTE_ZERO)
		else $error("firmware revision visible while not running downloaded code");
	silrev_read_a: assert property (lnk.sel && lnk.rx_valid && state_reg == ST_CMD
		&& lnk.rx_data == {1'b0, ADDR_SILICON_REV} |=> tx_reg == SILICON_REV)
		else $error("silicon revision read wrong");
	running_flag_a: assert property (firmware_running |=> obs_reg[OBS_RUNNING_BIT])
		else $error("running flag not set");
	pd_flag_a: assert property ($fell(pd_filt_reg) |=> obs_reg[OBS_PD_BIT])
		else $error("power-down pulse flag not set");
	frame_flags_a: assert property (frame_tick |=> obs_reg[1:0] == 2'b11)
		else $error("frame flags not set");
	obs_clear_a: assert property (obs_write && lnk.rx_data == BYTE_ZERO && obs_set == BYTE_ZERO |=> obs_reg == BYTE_ZERO)
		else $error("observation clear failed");
	cpart_code_a: assert property (lnk.sel && lnk.rx_valid && state_reg == ST_CMD
		&& lnk.rx_data == {1'b0, ADDR_CPART_CODE} |=> tx_reg == ~PART_CODE)
		else $error("complemented part code mismatch");
	pixel_step_a: assert property (lnk.sel && lnk.rx_valid && state_reg == ST_PBURST
		&& pixel_index < PIX_W'(PIX_LEN) |=> pixel_index == $past(pixel_index) + PIX_W'(1))
		else $error("pixel index did not advance");
	motion_first_a: assert property (lnk.sel && lnk.rx_valid && state_reg == ST_CMD
		&& lnk.rx_data == {1'b0, ADDR_MOTION_BURST} |=> tx_reg == $past(motion_in) ##0 state_reg == ST_MBURST)
		else $error("motion burst did not start with motion byte");
	load_pass_a: assert property (lnk.sel && lnk.rx_valid && state_reg == ST_LOAD
		|=> fw_load_valid && fw_load_data == $past(lnk.rx_data))
		else $error("download byte not passed on");
	reserved_zero_a: assert property (lnk.sel && lnk.rx_valid && state_reg == ST_CMD && !lnk.rx_data[7]
		&& (lnk.rx_data[6:0] inside {[7'h20:7'h3C], 7'h3E}) |=> tx_reg == BYTE_ZERO)
		else $error("reserved address not zero");
endmodule

`default_nettype wire

// >>> test/ssbr_host_model.sv
// Serial controller model: mode 3, MSB first, 200 ns link clock.
// Assumes the core clock paces it; pins change just after its edges.
`default_nettype none

module ssbr_host_model
(
	input wire logic clk,
	input wire logic miso_o,
	input wire logic miso_oe,
	output logic ncs_pin,
	output logic sclk_pin,
	output logic mosi_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last = 1'b0;
	// Released line shows the inverse of its last bit
	wire logic line = miso_oe ? miso_o : ~last;

	initial
	begin
		ncs_pin = 1'b1;
		sclk_pin = 1'b1;
		mosi_pin = 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic open_frame;
		ncs_pin = 1'b0;
		wt(4);
	endtask

	task automatic close_frame;
		wt(4);
		ncs_pin = 1'b1;
		wt(8);
	endtask

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			sclk_pin = 1'b0;
			mosi_pin = tx[i];
			wt(4);
			sclk_pin = 1'b1;
			wt(3);
			rx[i] = line;
			last = line;
			wt(1);
		end
	endtask
endmodule

`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the upper register map block.
// Assumes the serial controller model and a 40 MHz core clock.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ssbr_pkg::*;
	// Arbitrary identity values
	localparam logic [7:0] PC = 8'hC6;
	localparam logic [7:0] SR = 8'h3B;
	localparam int PL = 6;
	logic clk = 1'b0, nrst = 1'b0, power_down_n = 1'b1, frame_tick = 1'b0;
	logic firmware_running = 1'b0, fw_download_ok = 1'b0;
	logic ncs_pin, sclk_pin, mosi_pin, miso_o, miso_oe, fw_load_valid, fw_load_active;
	logic [7:0] fw_revision = 8'h00, motion_in = 8'h00, delta_x_in = 8'h00, delta_y_in = 8'h00;
	logic [7:0] surface_quality = 8'h00, max_pixel_in = 8'h00, pixel_data, fw_load_data, b;
	logic [15:0] shutter_in = 16'h0000;
	logic [10:0] pixel_index;
	logic [7:0] q [$];
	logic [7:0] pq [$];
	int mismatches = 0;
	int tests_run = 0;

	always #12.5 clk = ~clk;

	function automatic logic [7:0] pixel_fn(input logic [10:0] i);
		return i[7:0] ^ 8'hA5;
	endfunction

	assign pixel_data = pixel_fn(pixel_index);

	always @(posedge clk)
		if (fw_load_valid === 1'b1)
			q.push_back(fw_load_data);

	ssbr_regs #(.PART_CODE(PC), .SILICON_REV(SR), .PIX_LEN(PL)) ssbr_regs_inst
	(
		.clk, .nrst, .ncs_pin, .sclk_pin, .mosi_pin, .miso_o, .miso_oe, .power_down_n,
		.frame_tick, .firmware_running, .fw_download_ok, .fw_revision, .motion_in,
		.delta_x_in, .delta_y_in, .surface_quality, .shutter_in, .max_pixel_in,
		.pixel_index, .pixel_data, .fw_load_valid, .fw_load_data, .fw_load_active
	);

	ssbr_host_model ssbr_host_model_inst
	(
		.clk, .miso_o, .miso_oe, .ncs_pin, .sclk_pin, .mosi_pin
	);

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic burst(input string n, input logic [7:0] c, input logic [7:0] e [$]);
		logic [7:0] d;
		ssbr_host_model_inst.open_frame;
		ssbr_host_model_inst.xfer(c, d);
		foreach (e[i])
		begin
			ssbr_host_model_inst.xfer(8'($urandom), d);
			chk(n, e[i], d);
		end
		ssbr_host_model_inst.close_frame;
	endtask

	task automatic rchk(input string n, input logic [6:0] a, input logic [7:0] e);
		burst(n, {1'b0, a}, '{e});
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		ssbr_host_model_inst.open_frame;
		ssbr_host_model_inst.xfer({1'b1, a}, b);
		ssbr_host_model_inst.xfer(d, b);
		ssbr_host_model_inst.close_frame;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic done(input string n);
		$display("test %s done", n);
	endtask

	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#1ms;
		mismatches++;
		wrap_up;
	end

	initial
	begin
		void'($urandom(32'hc3e699c5));
		cyc(3);
		nrst = 1'b1;
		chk("idle outputs", 8'h00, {miso_oe, fw_load_valid, fw_load_active, 5'h00});
		chk("pixel index", 8'h00, pixel_index[7:0]);
		cyc(8);
		rchk("complement part code", ADDR_CPART_CODE, ~PC);
		rchk("silicon revision", ADDR_SILICON_REV, SR);
		rchk("part code", ADDR_PART_CODE, PC);
		done("identity");
		for (int k = 0; k < 4; k++)
		begin
			fw_revision = 8'($urandom) | 8'h01;
			{firmware_running, fw_download_ok} = 2'(k);
			rchk("firmware revision", ADDR_FW_REV, k == 3 ? fw_revision : 8'h00);
		end
		repeat (4)
			rchk("reserved", 7'h20 + 7'($urandom % 29), 8'h00);
		rchk("reserved", 7'h3E, 8'h00);
		done("revision and reserved");
		firmware_running = 1'b0;
		wr(ADDR_OBS, 8'h00);
		rchk("obs cleared", ADDR_OBS, 8'h00);
		frame_tick = 1'b1;
		cyc(1);
		frame_tick = 1'b0;
		rchk("obs frame", ADDR_OBS, 8'h03);
		power_down_n = 1'b0;
		cyc(10);
		power_down_n = 1'b1;
		rchk("obs powerdown", ADDR_OBS, 8'h23);
		firmware_running = 1'b1;
		rchk("obs running", ADDR_OBS, 8'hA3);
		wr(ADDR_OBS, 8'h00);
		rchk("obs running kept", ADDR_OBS, 8'h80);
		firmware_running = 1'b0;
		wr(ADDR_OBS, 8'h00);
		rchk("obs idle", ADDR_OBS, 8'h00);
		done("observation");
		{motion_in, delta_x_in, delta_y_in, surface_quality, max_pixel_in} = 40'({$urandom, $urandom});
		shutter_in = 16'($urandom);
		burst("motion burst", {1'b0, ADDR_MOTION_BURST}, '{motion_in, delta_x_in, delta_y_in,
			surface_quality, shutter_in[15:8], shutter_in[7:0], max_pixel_in, 8'h00});
		for (int i = 0; i < PL; i++)
			pq.push_back(pixel_fn(11'(i)));
		pq.push_back(8'h00);
		repeat (2)
			burst("pixel burst", {1'b0, ADDR_PIXEL_BURST}, pq);
		done("bursts");
		q.delete();
		pq = '{8'hFF};
		ssbr_host_model_inst.open_frame;
		ssbr_host_model_inst.xfer({1'b1, ADDR_FW_LOAD}, b);
		ssbr_host_model_inst.xfer(8'hFF, b);
		repeat (4)
		begin
			pq.push_back(8'($urandom));
			ssbr_host_model_inst.xfer(pq[$], b);
		end
		chk("download active", 8'h01, 8'(fw_load_active));
		ssbr_host_model_inst.close_frame;
		chk("download active", 8'h00, 8'(fw_load_active));
		chk("download count", 8'(pq.size()), 8'(q.size()));
		foreach (pq[i])
			chk("download byte", pq[i], q[i]);
		done("download");
		wrap_up;
	end
endmodule

`default_nettype wire
